// >>> verilog/spb_pkg.sv
// shared constants and types for the synchronous peripheral bus cycle
package spb_pkg;
  // timing base
  localparam int CLK_NS = 10;
  localparam int SYS_CLK_NS = 20;
  localparam int SYS_DIV = SYS_CLK_NS / CLK_NS;
  localparam int E_DIV = 10;
  localparam int E_LOW_SYS = 6;
  localparam int REC_WORST_SYS = 2;
  localparam int E_PERIOD = E_DIV * SYS_DIV;

  localparam int CNT_W = 5;
  typedef logic [CNT_W-1:0] spb_cnt_t;
  localparam spb_cnt_t CNT_LAST = spb_cnt_t'(E_PERIOD - 1);
  localparam spb_cnt_t CNT_E_RISE = spb_cnt_t'(E_LOW_SYS * SYS_DIV);
  localparam spb_cnt_t CNT_REC_LAST =
    spb_cnt_t'(E_LOW_SYS * SYS_DIV - REC_WORST_SYS * SYS_DIV - 1);
  localparam spb_cnt_t CNT_PRE_S5 = spb_cnt_t'(E_PERIOD - 3);

  // function codes and autovectoring
  localparam int FC_W = 3;
  localparam int LVL_W = 3;
  localparam logic [FC_W-1:0] FC_CPU_SPACE = 3'h7;
  localparam logic [7:0] AUTOVEC_BASE = 8'h18;

  typedef enum logic [3:0] {
    ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4,
    ST_WAIT, ST_S5, ST_S6, ST_S7, ST_S8
  } spb_state_e;
endpackage

// >>> verilog/spb_sync.sv
// two-stage synchroniser for pin inputs
module spb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  if (W < 1) begin : g_chk
    $error("spb_sync: width must be at least one");
  end

  always_comb begin
    meta_nxt = din;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign dout = sync_r;
endmodule

// >>> verilog/spb_ediv.sv
// free-running enable clock divider
module spb_ediv #(
  parameter int PERIOD = spb_pkg::E_PERIOD,
  parameter spb_pkg::spb_cnt_t RISE = spb_pkg::CNT_E_RISE
) (
  input wire logic clock,
  input wire logic sys_rst,
  output spb_pkg::spb_cnt_t cnt,
  output logic e_clk
);
  spb_pkg::spb_cnt_t cnt_r;
  spb_pkg::spb_cnt_t cnt_nxt;
  logic e_r;
  logic e_nxt;

  if (PERIOD < 2 || PERIOD > (1 << spb_pkg::CNT_W) || int'(RISE) >= PERIOD) begin : g_chk
    $error("spb_ediv: period or rise point out of range");
  end

  always_comb begin
    cnt_nxt = (cnt_r == spb_cnt_last()) ? '0 : cnt_r + 1'b1;
    e_nxt = (cnt_nxt >= RISE);
  end

  function automatic spb_pkg::spb_cnt_t spb_cnt_last();
    spb_cnt_last = spb_pkg::spb_cnt_t'(PERIOD - 1);
  endfunction

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_r <= '0;
      e_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      e_r <= e_nxt;
    end
  end

  assign cnt = cnt_r;
  assign e_clk = e_r;

  AST_FREE_RUN: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(sys_rst) |-> cnt_r != $past(cnt_r))
    else $error("enable divider stalled");
endmodule

// >>> verilog/spb_core.sv
// synchronous peripheral bus cycle engine with enable clock
// Notes on behaviour
// - enable clock is system clock over ten
// - enable low six clocks, high four
// - state 0: address floats, function code driven
// - address in S1; strobe, read strobes/write in S2
// - write: data in S3, strobes in S4
// - wait states until peripheral request sampled
// - after recognition, select asserted while enable low, held through S7
// - earliest recognition at end of S4
// - recognition at least two clocks before rise, else next pulse
// - read data latched in state 6
// - S7 strobes drop with enable; then float
// - interrupt acknowledge completes with autovector 25-31
module spb_core #(
  parameter int ADDR_W = 23,
  parameter int DATA_W = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_iack,
  input wire logic [spb_pkg::FC_W-1:0] req_fc,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic req_upper,
  input wire logic req_lower,
  input wire logic [spb_pkg::LVL_W-1:0] req_level,
  output logic req_ready,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic [7:0] autovector,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_i,
  output logic [spb_pkg::FC_W-1:0] fc_o,
  output logic addr_valid_strobe_n,
  output logic upper_byte_strobe_n,
  output logic lower_byte_strobe_n,
  output logic read_write,
  input wire logic sync_peripheral_request_n,
  output logic valid_peripheral_select_n,
  output logic e_clk
);
  if (ADDR_W <= spb_pkg::LVL_W || DATA_W < 8) begin : g_chk
    $error("spb_core: address or data width too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // enable clock and pin synchronisers

  spb_pkg::spb_cnt_t cnt;
  logic spr_s_n;
  logic [DATA_W-1:0] data_s;

  spb_ediv u_ediv (
    .clock(clock),
    .sys_rst(sys_rst),
    .cnt(cnt),
    .e_clk(e_clk)
  );

  spb_sync #(.W(1), .RST_VAL(1'b1)) u_spr_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .din(sync_peripheral_request_n),
    .dout(spr_s_n)
  );

  spb_sync #(.W(DATA_W), .RST_VAL('0)) u_data_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .din(data_i),
    .dout(data_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // cycle state and latched request

  spb_pkg::spb_state_e state_r, state_nxt;
  logic rec_r, rec_nxt;
  logic commit_r, commit_nxt;
  logic wr_r, wr_nxt;
  logic iack_r, iack_nxt;
  logic ub_r, ub_nxt;
  logic lb_r, lb_nxt;
  logic [spb_pkg::LVL_W-1:0] lvl_r, lvl_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [spb_pkg::FC_W-1:0] fc_r, fc_nxt;
  logic take;
  logic recog;

  always_comb begin
    state_nxt = state_r;
    rec_nxt = rec_r;
    commit_nxt = commit_r;
    wr_nxt = wr_r;
    iack_nxt = iack_r;
    ub_nxt = ub_r;
    lb_nxt = lb_r;
    lvl_nxt = lvl_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    fc_nxt = fc_r;
    take = req_ready && req_valid;
    // request sampled only at falling system clock edges from S4 on
    recog = cnt[0] && !spr_s_n
      && (state_r == spb_pkg::ST_S4 || state_r == spb_pkg::ST_WAIT);
    unique case (state_r)
      spb_pkg::ST_IDLE: begin
        if (take) begin
          state_nxt = spb_pkg::ST_S0;
          wr_nxt = req_write && !req_iack;
          iack_nxt = req_iack;
          ub_nxt = req_upper;
          lb_nxt = req_lower;
          lvl_nxt = req_level;
          wdata_nxt = req_wdata;
          fc_nxt = req_iack ? spb_pkg::FC_CPU_SPACE : req_fc;
          addr_nxt = req_iack ? {{(ADDR_W - spb_pkg::LVL_W){1'b1}}, req_level} : req_addr;
        end
      end
      spb_pkg::ST_S0: state_nxt = spb_pkg::ST_S1;
      spb_pkg::ST_S1: state_nxt = spb_pkg::ST_S2;
      spb_pkg::ST_S2: state_nxt = spb_pkg::ST_S3;
      spb_pkg::ST_S3: state_nxt = spb_pkg::ST_S4;
      spb_pkg::ST_S4: state_nxt = spb_pkg::ST_WAIT;
      spb_pkg::ST_WAIT: begin
        if (commit_r && cnt == spb_pkg::CNT_PRE_S5) begin
          state_nxt = spb_pkg::ST_S5;
        end
      end
      spb_pkg::ST_S5: state_nxt = spb_pkg::ST_S6;
      spb_pkg::ST_S6: state_nxt = spb_pkg::ST_S7;
      spb_pkg::ST_S7: state_nxt = spb_pkg::ST_S8;
      spb_pkg::ST_S8: state_nxt = spb_pkg::ST_IDLE;
    endcase
    if (state_nxt == spb_pkg::ST_IDLE) begin
      rec_nxt = 1'b0;
      commit_nxt = 1'b0;
    end else begin
      if (recog) begin
        rec_nxt = 1'b1;
      end
      // join this enable pulse only if at least two clocks remain
      if (rec_nxt && cnt <= spb_pkg::CNT_REC_LAST) begin
        commit_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= spb_pkg::ST_IDLE;
      rec_r <= 1'b0;
      commit_r <= 1'b0;
      wr_r <= 1'b0;
      iack_r <= 1'b0;
      ub_r <= 1'b0;
      lb_r <= 1'b0;
      lvl_r <= '0;
      addr_r <= '0;
      wdata_r <= '0;
      fc_r <= '0;
    end else begin
      state_r <= state_nxt;
      rec_r <= rec_nxt;
      commit_r <= commit_nxt;
      wr_r <= wr_nxt;
      iack_r <= iack_nxt;
      ub_r <= ub_nxt;
      lb_r <= lb_nxt;
      lvl_r <= lvl_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      fc_r <= fc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pin and user outputs, derived from the next state; read data and autovector from the current state

  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [7:0] avec_r, avec_nxt;
  logic aoe_r, aoe_nxt;
  logic doe_r, doe_nxt;
  logic [spb_pkg::FC_W-1:0] fco_r, fco_nxt;
  logic avs_n_r, avs_n_nxt;
  logic ustb_n_r, ustb_n_nxt;
  logic lstb_n_r, lstb_n_nxt;
  logic rw_r, rw_nxt;
  logic vps_n_r, vps_n_nxt;
  logic strb;

  always_comb begin
    // next count parity flips every cycle; start S0 on a high half
    ready_nxt = (state_nxt == spb_pkg::ST_IDLE) && cnt[0];
    done_nxt = (state_nxt == spb_pkg::ST_S8);
    fco_nxt = (state_nxt == spb_pkg::ST_IDLE) ? fco_r : fc_nxt;
    aoe_nxt = state_nxt inside {spb_pkg::ST_S1, spb_pkg::ST_S2, spb_pkg::ST_S3,
      spb_pkg::ST_S4, spb_pkg::ST_WAIT, spb_pkg::ST_S5, spb_pkg::ST_S6,
      spb_pkg::ST_S7};
    avs_n_nxt = !(state_nxt inside {spb_pkg::ST_S2, spb_pkg::ST_S3, spb_pkg::ST_S4,
      spb_pkg::ST_WAIT, spb_pkg::ST_S5, spb_pkg::ST_S6});
    if (wr_nxt) begin
      strb = state_nxt inside {spb_pkg::ST_S4, spb_pkg::ST_WAIT, spb_pkg::ST_S5,
        spb_pkg::ST_S6};
    end else begin
      strb = !avs_n_nxt;
    end
    ustb_n_nxt = !(strb && ub_nxt);
    lstb_n_nxt = !(strb && lb_nxt);
    rw_nxt = !(wr_nxt && aoe_nxt && state_nxt != spb_pkg::ST_S1);
    doe_nxt = wr_nxt && (state_nxt inside {spb_pkg::ST_S3, spb_pkg::ST_S4,
      spb_pkg::ST_WAIT, spb_pkg::ST_S5, spb_pkg::ST_S6, spb_pkg::ST_S7});
    vps_n_nxt = !(commit_nxt && (state_nxt inside {spb_pkg::ST_S4,
      spb_pkg::ST_WAIT, spb_pkg::ST_S5, spb_pkg::ST_S6, spb_pkg::ST_S7}));
    rdata_nxt = rdata_r;
    avec_nxt = avec_r;
    if (state_r == spb_pkg::ST_S6 && !wr_r) begin
      rdata_nxt = data_s;
      if (iack_r) begin
        avec_nxt = spb_pkg::AUTOVEC_BASE | {5'h00, lvl_r};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ready_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= '0;
      avec_r <= '0;
      aoe_r <= 1'b0;
      doe_r <= 1'b0;
      fco_r <= '0;
      avs_n_r <= 1'b1;
      ustb_n_r <= 1'b1;
      lstb_n_r <= 1'b1;
      rw_r <= 1'b1;
      vps_n_r <= 1'b1;
    end else begin
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      avec_r <= avec_nxt;
      aoe_r <= aoe_nxt;
      doe_r <= doe_nxt;
      fco_r <= fco_nxt;
      avs_n_r <= avs_n_nxt;
      ustb_n_r <= ustb_n_nxt;
      lstb_n_r <= lstb_n_nxt;
      rw_r <= rw_nxt;
      vps_n_r <= vps_n_nxt;
    end
  end

  assign req_ready = ready_r;
  assign done = done_r;
  assign rdata = rdata_r;
  assign autovector = avec_r;
  assign addr_o = addr_r;
  assign addr_oe = aoe_r;
  assign data_o = wdata_r;
  assign data_oe = doe_r;
  assign fc_o = fco_r;
  assign addr_valid_strobe_n = avs_n_r;
  assign upper_byte_strobe_n = ustb_n_r;
  assign lower_byte_strobe_n = lstb_n_r;
  assign read_write = rw_r;
  assign valid_peripheral_select_n = vps_n_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_E_PERIOD: assert property ($rose(e_clk) |-> ##20 $rose(e_clk))
    else $error("enable period is not ten system clocks");
  AST_E_HIGH: assert property ($rose(e_clk) |-> e_clk [*8] ##1 !e_clk)
    else $error("enable high time is not four system clocks");
  AST_S0_FLOAT: assert property (state_r == spb_pkg::ST_S0 |->
    !addr_oe ##1 addr_oe && addr_valid_strobe_n ##1 !addr_valid_strobe_n)
    else $error("address phase order wrong");
  AST_RD_STROBE: assert property ($fell(addr_valid_strobe_n) && read_write |->
    (!upper_byte_strobe_n || !lower_byte_strobe_n || !(ub_r || lb_r)))
    else $error("read strobes not with address strobe");
  AST_WR_DATA: assert property ($fell(read_write) |->
    !data_oe ##1 data_oe ##1 (upper_byte_strobe_n == !ub_r))
    else $error("write data or strobe timing wrong");
  AST_WAIT: assert property (state_r == spb_pkg::ST_WAIT && !rec_r && spr_s_n
    |=> state_r == spb_pkg::ST_WAIT)
    else $error("left wait without request");
  AST_VPS_ELOW: assert property ($fell(valid_peripheral_select_n) |->
    !e_clk && $past(rec_nxt))
    else $error("select asserted while enable high or unrecognised");
  AST_VPS_RISE: assert property ($fell(valid_peripheral_select_n) |->
    ##[4:11] $rose(e_clk))
    else $error("synchronisation delay out of range");
  AST_LATCH: assert property (done && read_write && $past(!wr_r) |->
    rdata == $past(data_s, 2))
    else $error("read data not latched in state 6");
  AST_NEGATE: assert property ($rose(addr_valid_strobe_n) |->
    $fell(e_clk) ##1 (!addr_oe && read_write && done))
    else $error("end of cycle misaligned");
  AST_AUTOVEC: assert property (done && iack_r |->
    autovector == (spb_pkg::AUTOVEC_BASE | {5'h00, lvl_r}))
    else $error("wrong autovector");
endmodule

// >>> tb/spb_periph.sv
// slow synchronous peripheral and its address decode, seen from the pins
module spb_periph (
  input wire logic clock,
  input wire logic [7:0] req_delay,
  input wire logic [15:0] rd_word,
  input wire logic addr_valid_strobe_n,
  input wire logic read_write,
  input wire logic valid_peripheral_select_n,
  input wire logic e_clk,
  input wire logic [15:0] data_o,
  output logic sync_peripheral_request_n,
  output logic [15:0] data_i,
  output logic [15:0] wr_seen,
  output logic ext_sel_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] wait_cnt;
  logic e_d;
  logic arm_r;
  initial begin
    arm_r = 1'b0;
    ext_sel_n = 1'b1;
    wait_cnt = 8'h00;
    e_d = 1'b0;
    wr_seen = 16'h0000;
    sync_peripheral_request_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // decode qualified by strobe, no handshake acknowledge exists here
  always @(posedge clock) begin
    e_d <= e_clk;
    if (addr_valid_strobe_n) begin
      wait_cnt <= 8'h00;
      sync_peripheral_request_n <= 1'b1;
    end else if (wait_cnt == req_delay) begin
      sync_peripheral_request_n <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 8'h01;
    end
    // write taken as enable falls while selected
    if (e_d && !e_clk && !valid_peripheral_select_n && !read_write) begin
      wr_seen <= data_o;
    end
    // stand-in select logic for a part that has no select output
    if (sync_peripheral_request_n) begin
      arm_r <= 1'b0;
      ext_sel_n <= 1'b1;
    end else begin
      if (e_d && !e_clk) begin
        arm_r <= 1'b1;
      end
      if (arm_r) begin
        ext_sel_n <= 1'b0;
      end
    end
  end
  // data only while selected with enable high, else inverted
  assign data_i = (!valid_peripheral_select_n && e_clk && read_write) ? rd_word : ~rd_word;
endmodule

// >>> tb/test_sync_peripheral_bus_cycle.sv
// self-checking bench for the synchronous peripheral bus cycle engine
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (a), (b)); end end
module test_sync_peripheral_bus_cycle;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_iack = 1'b0;
  logic [2:0] req_fc = 3'h5, req_level = 3'h0, fc_o;
  logic [22:0] req_addr = 23'h000000, addr_o;
  logic [15:0] req_wdata = 16'h0000, rdata, data_o, data_i, rd_word = 16'h0000, wr_seen;
  logic req_upper = 1'b1, req_lower = 1'b1, req_ready, done, addr_oe, data_oe, read_write;
  logic addr_valid_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, e_clk;
  logic sync_peripheral_request_n, valid_peripheral_select_n, ext_sel_n;
  logic [7:0] autovector, req_delay = 8'h00;
  int err_count = 0, checks_done = 0;
  spb_core dut (.clock, .sys_rst, .req_valid, .req_write, .req_iack, .req_fc, .req_addr,
    .req_wdata, .req_upper, .req_lower, .req_level, .req_ready, .done, .rdata, .autovector,
    .addr_o, .addr_oe, .data_o, .data_oe, .data_i, .fc_o, .addr_valid_strobe_n,
    .upper_byte_strobe_n, .lower_byte_strobe_n, .read_write, .sync_peripheral_request_n,
    .valid_peripheral_select_n, .e_clk);
  spb_periph periph (.clock, .req_delay, .rd_word, .addr_valid_strobe_n, .read_write,
    .valid_peripheral_select_n, .e_clk, .data_o, .sync_peripheral_request_n, .data_i, .wr_seen,
    .ext_sel_n);
  initial begin
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  // one bus cycle with pin checks along the way
  task automatic xfer(input logic wr, input logic ia, input logic [22:0] ad,
                      input logic [15:0] wd, input logic [2:0] lv);
    int n, sel_t, rise_t;
    logic addr_seen, data_seen;
    n = 0;
    sel_t = -1;
    rise_t = -1;
    addr_seen = 1'b0;
    data_seen = 1'b0;
    req_write = wr;
    req_iack = ia;
    req_addr = ad;
    req_wdata = wd;
    req_level = lv;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    step();
    req_valid = 1'b0;
    `CHK(addr_oe, 1'b0)
    `CHK(fc_o, ia ? spb_pkg::FC_CPU_SPACE : req_fc)
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      step();
      n++;
      if (addr_valid_strobe_n === 1'b0 && !addr_seen) begin
        addr_seen = 1'b1;
        `CHK(addr_o, ia ? {20'hFFFFF, lv} : ad)
        `CHK(read_write, ~wr | ia)
        `CHK(upper_byte_strobe_n, (wr & ~ia) | ~req_upper)
        `CHK(lower_byte_strobe_n, (wr & ~ia) | ~req_lower)
      end
      if (wr && upper_byte_strobe_n === 1'b0 && !data_seen) begin
        data_seen = 1'b1;
        `CHK(data_oe, 1'b1)
        `CHK(lower_byte_strobe_n, ~req_lower)
      end
      if (valid_peripheral_select_n === 1'b0 && sel_t < 0) begin
        sel_t = n;
        `CHK(e_clk, 1'b0)
        `CHK(sync_peripheral_request_n, 1'b0)
      end
      if (e_clk === 1'b1 && rise_t < 0 && sel_t >= 0) rise_t = n;
    end
    `CHK(done, 1'b1)
    `CHK(rise_t - sel_t >= 4 && rise_t - sel_t <= 11, 1'b1)
    `CHK(addr_oe, 1'b0)
    `CHK(read_write, 1'b1)
    `CHK(addr_valid_strobe_n, 1'b1)
    `CHK(valid_peripheral_select_n, 1'b1)
    step();
    `CHK(ext_sel_n, 1'b1)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_eclk();
    int n, hi, first;
    n = 0;
    hi = 0;
    first = -1;
    while (e_clk !== 1'b1 && n < 40) begin step(); n++; end
    while (e_clk !== 1'b0 && n < 40) begin step(); n++; end
    for (int i = 0; i < 20; i++) begin
      if (e_clk === 1'b1 && first < 0) first = i;
      if (e_clk === 1'b1) hi++;
      step();
    end
    `CHK(hi, 8)
    `CHK(first, 12)
  endtask
  task automatic test_reads();
    rd_word = 16'h3C5A;
    xfer(1'b0, 1'b0, 23'h00A5A5, 16'h0000, 3'h0);
    `CHK(rdata, 16'h3C5A)
    rd_word = 16'hC3A5;
    xfer(1'b0, 1'b0, 23'h7FFFFE, 16'h0000, 3'h0);
    `CHK(rdata, 16'hC3A5)
  endtask
  task automatic test_write();
    req_lower = 1'b0;
    xfer(1'b1, 1'b0, 23'h012345, 16'hA5C3, 3'h0);
    `CHK(wr_seen, 16'hA5C3)
    req_lower = 1'b1;
  endtask
  task automatic test_slow();
    req_delay = 8'h1E;
    rd_word = 16'h0F1E;
    xfer(1'b0, 1'b0, 23'h001000, 16'h0000, 3'h0);
    `CHK(rdata, 16'h0F1E)
    req_delay = 8'h00;
  endtask
  task automatic test_iack();
    for (int l = 1; l < 8; l++) begin
      xfer(1'b0, 1'b1, 23'h7FFFFF, 16'h0000, 3'(l));
      `CHK(autovector, spb_pkg::AUTOVEC_BASE | {5'h00, 3'(l)})
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    #1;
    `CHK(valid_peripheral_select_n, 1'b1)
    `CHK(e_clk, 1'b0)
    sys_rst = 1'b0;
    test_eclk();
    test_reads();
    test_write();
    test_slow();
    test_iack();
    test_eclk();
    test_done();
  end
  initial begin
    #50000;
    err_count++;
    test_done();
  end
endmodule
